// ---- cpr_loader_model.sv ----
// Loading device: makes the link clock per frame and captures data.
// Assumes the bench waits on o_busy.
`timescale 1ns/1ps
`default_nettype none
module cpr_loader_model import cpr_pkg::*; (
   input  wire logic           i_go,
   input  wire logic [10:0]    i_pulses,
   input  wire cpr_data_pins_t i_bus,
   output var  logic           o_configuration_clock,
   output var  logic           o_busy);
   cpr_data_pins_t cap [0:1023];
   initial begin
      o_configuration_clock = 1'b0;
      o_busy = 1'b0;
      forever begin
         @(posedge i_go);
         o_busy = 1'b1;
         #1137;
         for (int k = 0; k < i_pulses; k++) begin
            cap[k] = i_bus;
            o_configuration_clock = 1'b1;
            #400 o_configuration_clock = 1'b0;
            #400;
         end
         o_busy = 1'b0;
      end
   end
endmodule : cpr_loader_model
`default_nettype wire

// ---- cpr_pkg.sv ----
// Constants and carrier types for the configuration memory read-out block.
// Assumes a single system clock domain; pins are resynchronised inside the block.
package cpr_pkg;
   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int              CPR_ADDR_W    = 10;
   localparam int              CPR_DATA_W    = 8;
   localparam int              CPR_DEPTH     = 1024;
   localparam logic [9:0]      CPR_ADDR_ZERO = 10'h000;
   localparam logic [9:0]      CPR_ADDR_ONE  = 10'h001;
   // Last word address, stands for terminal_count
   localparam logic [9:0]      CPR_TERMINAL_COUNT = 10'h3ff;
   localparam logic [2:0]      CPR_BIT_ZERO  = 3'h0;
   localparam logic [2:0]      CPR_BIT_ONE   = 3'h1;
   localparam logic [2:0]      CPR_BIT_LAST  = 3'h7;
   localparam logic [7:0]      CPR_BYTE_ZERO = 8'h00;
   // Synchroniser reset levels
   localparam logic [1:0]      CPR_SYNC_LOW  = 2'h0;
   localparam logic [1:0]      CPR_SYNC_HIGH = 2'h3;
   // Data line enables
   localparam logic [7:0]      CPR_OE_ALL    = 8'hff;
   localparam logic [7:0]      CPR_OE_SERIAL = 8'h01;
   localparam logic [6:0]      CPR_UPPER_ZERO = 7'h00;

   // ----------------------------------------
   // Carrier for the data pins
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe;
   } cpr_data_pins_t;
endpackage : cpr_pkg

// ---- cpr_readout.sv ----
// Read-out logic of a configuration memory: counter, word store, pin drive.
// Assumes the link and mode pins arrive asynchronously and are resynchronised here.
`timescale 1ns/1ps
`default_nettype none
module cpr_readout
   import cpr_pkg::*;
(
   // System
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // Mode strap: high selects parallel
   input  wire logic                  i_parallel_mode,
   // Link pins
   input  wire logic                  i_configuration_clock,
   input  wire logic                  i_chip_select_n,
   input  wire logic                  i_oe_reset_n,
   output var  logic                  o_oe_reset_n_out,
   output var  logic                  o_oe_reset_n_oe,
   output var  cpr_data_pins_t        o_parallel_data_bus,
   output var  logic                  o_cascade_select_out_n,
   // Store load port, same clock
   input  wire logic                  i_load_we,
   input  wire logic [CPR_ADDR_W-1:0] i_load_addr,
   input  wire logic [CPR_DATA_W-1:0] i_load_data
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] clk_sync_reg;
   logic [1:0] cs_sync_reg;
   logic [1:0] oe_sync_reg;
   logic [1:0] mode_sync_reg;
   logic       clk_prev_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         clk_sync_reg <= CPR_SYNC_LOW;
      end else begin
         clk_sync_reg <= {clk_sync_reg[0], i_configuration_clock};
      end
   end

   // Select idles high so no false select follows reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_sync_reg <= CPR_SYNC_HIGH;
      end else begin
         cs_sync_reg <= {cs_sync_reg[0], i_chip_select_n};
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         oe_sync_reg <= CPR_SYNC_LOW;
      end else begin
         oe_sync_reg <= {oe_sync_reg[0], i_oe_reset_n};
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_sync_reg <= CPR_SYNC_LOW;
      end else begin
         mode_sync_reg <= {mode_sync_reg[0], i_parallel_mode};
      end
   end

   // ----------------------------------------
   // Link edge detect
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         clk_prev_reg <= 1'b0;
      end else begin
         clk_prev_reg <= clk_sync_reg[1];
      end
   end

   logic rise;
   logic cs_n;
   logic oe_n_in;
   logic par;
   logic active;
   assign rise    = clk_sync_reg[1] & ~clk_prev_reg;
   assign cs_n    = cs_sync_reg[1];
   assign oe_n_in = oe_sync_reg[1];
   assign par     = mode_sync_reg[1];
   assign active  = ~cs_n & oe_n_in;

   // ----------------------------------------
   // Word store
   // ----------------------------------------
   logic [CPR_DATA_W-1:0] mem [CPR_DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_load_we) begin
         mem[i_load_addr] <= i_load_data;
      end
   end

   // ----------------------------------------
   // Address and bit counters
   // ----------------------------------------
   logic [CPR_ADDR_W-1:0] addr_reg;
   logic [2:0]            bit_reg;
   logic                  past_tc_reg;
   logic                  last_step;
   assign last_step = par | (bit_reg == CPR_BIT_LAST);

   logic [CPR_ADDR_W-1:0] addr_next;
   logic [2:0]            bit_next;
   logic                  past_tc_next;

   // Counting stops once past terminal count until deactivated
   always_comb begin
      addr_next    = addr_reg;
      bit_next     = bit_reg;
      past_tc_next = past_tc_reg;
      if (!active) begin
         addr_next    = CPR_ADDR_ZERO;
         bit_next     = CPR_BIT_ZERO;
         past_tc_next = 1'b0;
      end else if (rise && !past_tc_reg) begin
         if (last_step) begin
            bit_next = CPR_BIT_ZERO;
            if (addr_reg == CPR_TERMINAL_COUNT) begin
               past_tc_next = 1'b1;
            end else begin
               addr_next = addr_reg + CPR_ADDR_ONE;
            end
         end else begin
            bit_next = bit_reg + CPR_BIT_ONE;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_reg <= CPR_ADDR_ZERO;
      end else begin
         addr_reg <= addr_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bit_reg <= CPR_BIT_ZERO;
      end else begin
         bit_reg <= bit_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         past_tc_reg <= 1'b0;
      end else begin
         past_tc_reg <= past_tc_next;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   logic [CPR_DATA_W-1:0] word;
   assign word = mem[addr_reg];

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_parallel_data_bus <= '0;
      end else if (!active || past_tc_reg) begin
         o_parallel_data_bus <= '0;
      end else if (par) begin
         o_parallel_data_bus.data <= word;
         o_parallel_data_bus.oe   <= CPR_OE_ALL;
      end else begin
         // Msb first in serial use; upper lines stay floating
         o_parallel_data_bus.data <= {CPR_UPPER_ZERO, word[CPR_BIT_LAST - bit_reg]};
         o_parallel_data_bus.oe   <= CPR_OE_SERIAL;
      end
   end

   // ----------------------------------------
   // Cascade and reset pin
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cascade_select_out_n <= 1'b1;
      end else begin
         o_cascade_select_out_n <= ~(active & past_tc_reg);
      end
   end

   // Open drain: only ever pulls low, and only while in reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_oe_reset_n_out <= 1'b0;
         o_oe_reset_n_oe  <= 1'b1;
      end else begin
         o_oe_reset_n_out <= 1'b0;
         o_oe_reset_n_oe  <= 1'b0;
      end
   end
endmodule : cpr_readout
`default_nettype wire

// ---- cpr_readout_asserts.sv ----
// Port-level checks for the configuration read-out block.
// Assumes pins stay steady for several clocks around each change.
`timescale 1ns/1ps
`default_nettype none
module cpr_readout_asserts import cpr_pkg::*; (
   input wire logic                  i_clk, i_rst, i_parallel_mode, i_configuration_clock,
   input wire logic                  i_chip_select_n, i_oe_reset_n, i_load_we,
   input wire logic                  o_oe_reset_n_out, o_oe_reset_n_oe, o_cascade_select_out_n,
   input wire cpr_data_pins_t        o_parallel_data_bus,
   input wire logic [CPR_ADDR_W-1:0] i_load_addr,
   input wire logic [CPR_DATA_W-1:0] i_load_data);
   wire [7:0] oe  = o_parallel_data_bus.oe;
   wire       cas = o_cascade_select_out_n;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_pin_low: assert property (o_oe_reset_n_out == 1'b0) else $error("pin not low");
   a_pin_release: assert property (1'b1 |=> !o_oe_reset_n_oe) else $error("pin held");
   a_serial_upper: assert property ((!i_parallel_mode)[*6] |-> oe[7:1] == 7'h00)
      else $error("upper lines driven");
   a_parallel_wide: assert property (i_parallel_mode[*6] |-> oe inside {8'h00, 8'hff})
      else $error("byte not full");
   a_select_idle: assert property (i_chip_select_n[*6] |-> oe == 8'h00 && cas)
      else $error("not idle");
   a_reset_idle: assert property ((!i_oe_reset_n)[*6] |-> oe == 8'h00 && cas)
      else $error("not held");
   a_hold_still: assert property (($stable(i_configuration_clock) && $stable(i_chip_select_n)
      && $stable(i_oe_reset_n) && $stable(i_parallel_mode))[*8] |-> $stable(oe))
      else $error("moved with no edge");
   a_cascade_cause: assert property ($fell(cas) |-> !i_chip_select_n && i_oe_reset_n)
      else $error("cascade fell");
   a_cascade_back: assert property (!cas && i_chip_select_n |-> ##[1:6] cas)
      else $error("cascade stuck");
   cover property ($fell(cas));
   cover property (oe == 8'hff);
   cover property (oe == 8'h01);
endmodule : cpr_readout_asserts
bind cpr_readout cpr_readout_asserts cpr_readout_asserts_inst (.*);
`default_nettype wire

// ---- tb_cpr_readout.sv ----
// Self-checking bench for the read-out block with a loader model.
// Assumes store load through the side port while deselected.
`timescale 1ns/1ps
`default_nettype none
module tb_cpr_readout;
   import cpr_pkg::*;
   logic i_clk = 0, i_rst = 1, pm = 0, cs_n = 1, oe_n = 1, we = 0, go = 0;
   logic [9:0] la = 0;
   logic [7:0] ld = 0, mem [0:1023];
   logic [10:0] np = 0;
   logic configuration_clock, busy, oe_oe, cas_n;
   cpr_data_pins_t bus;
   int failures = 0, comparisons = 0;
   wire rst_pin = oe_n & ~oe_oe;
   always #50 i_clk = ~i_clk;
   cpr_readout cpr_readout_inst (.i_clk(i_clk), .i_rst(i_rst), .i_parallel_mode(pm),
      .i_configuration_clock(configuration_clock), .i_chip_select_n(cs_n), .i_oe_reset_n(rst_pin),
      .o_oe_reset_n_out(), .o_oe_reset_n_oe(oe_oe), .o_parallel_data_bus(bus),
      .o_cascade_select_out_n(cas_n), .i_load_we(we), .i_load_addr(la), .i_load_data(ld));
   cpr_loader_model cpr_loader_model_inst (.i_go(go), .i_pulses(np), .i_bus(bus),
      .o_configuration_clock(configuration_clock), .o_busy(busy));
   function automatic logic [16:0] want(int k, logic p);
      return p ? {1'b0, mem[k], 8'hff} : {8'h00, mem[k/8][7-k%8], 8'h01};
   endfunction : want
   task automatic chk(input logic [16:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [16:0] cap(int k);
      cpr_data_pins_t c = cpr_loader_model_inst.cap[k];
      return {1'b0, c.data & c.oe, c.oe};
   endfunction : cap
   task automatic sel(input logic c, o, p);
      @(posedge i_clk) #5 {cs_n, oe_n, pm} = {c, o, p};
      repeat (8) @(posedge i_clk);
   endtask : sel
   task automatic run(input logic [10:0] n);
      @(posedge i_clk) #5 {np, go} = {n, 1'b1};
      @(posedge i_clk) #5 go = 0;
      while (busy) @(posedge i_clk);
      repeat (8) @(posedge i_clk);
   endtask : run
   task automatic wrap_up;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   initial begin
      #3000000 failures++;
      wrap_up;
   end
   initial begin
      void'($urandom(70));
      repeat (3) @(posedge i_clk);
      #5 i_rst = 0;
      for (int i = 0; i < 1024; i++) begin
         @(posedge i_clk) #5 {we, la, ld} = {1'b1, i[9:0], i < 2 ? 8'h80 >> (7*i) : 8'($urandom)};
         mem[i] = ld;
      end
      @(posedge i_clk) #5 we = 0;
      sel(0, 1, 1); run(6);
      for (int k = 0; k < 6; k++) chk(cap(k), want(k, 1));
      sel(1, 1, 1); chk({cas_n, bus}, 17'h10000);
      $display("parallel test done");
      sel(0, 1, 0); run(16);
      for (int k = 0; k < 16; k++) chk(cap(k), want(k, 0));
      sel(0, 0, 0); run(3); chk(cap(2), 17'h00000);
      sel(0, 1, 0); run(8);
      for (int k = 0; k < 8; k++) chk(cap(k), want(k, 0));
      $display("serial test done");
      sel(1, 1, 1); sel(0, 1, 1); run(1024);
      chk(cap(1023), want(1023, 1));
      chk({cas_n, bus}, 17'h00000);
      sel(1, 1, 1); chk({cas_n, bus}, 17'h10000);
      run(4); chk({cas_n, bus}, 17'h10000);
      sel(0, 1, 1); run(1); chk(cap(0), want(0, 1));
      $display("cascade test done");
      wrap_up;
   end
endmodule : tb_cpr_readout
`default_nettype wire
